// ---- verilog/suc_top.sv ----
// System and update register bank with sync control
//
// Strobed register access was chosen for this implementation.
`include "suc_cfg.svh"
module suc_top (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_b_in,
   input  wire suc_pkg::suc_addr_t reg_addr_in,
   input  wire suc_pkg::suc_byte_t reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output suc_pkg::suc_byte_t      reg_rdata_out,
   input  wire logic        sync_pin_b_in,
   output logic             sync_pd_out,
   output logic             dist_ref_pd_out,
   output logic             chan_hold_out,
   output logic             sync_event_out,
   output logic             update_out
);
   import suc_pkg::*;

   suc_byte_t buf_sys_r;
   suc_byte_t act_sys_r;
   logic      upd_r;
   suc_byte_t rdata_r;
   suc_byte_t rd_mux;
   suc_byte_t stat_byte;
   logic      pin_high;
   logic      wr_sys;
   logic      upd_set;
   logic      rd_sys;
   logic      rd_upd;
   logic      rd_stat;

   suc_sync_if sif ();

   // Address decode
   assign wr_sys  = reg_wr_in & suc_hit(reg_addr_in, `SUC_OFS_SYS);
   assign upd_set = reg_wr_in & suc_hit(reg_addr_in, `SUC_OFS_UPD)
                    & reg_wdata_in[`SUC_BIT_UPD];
   assign rd_sys  = suc_hit(reg_addr_in, `SUC_OFS_SYS);
   assign rd_upd  = suc_hit(reg_addr_in, `SUC_OFS_UPD);
   assign rd_stat = suc_hit(reg_addr_in, `SUC_OFS_STAT);

   // Status: pin level, hold state, active system bits
   assign stat_byte = (act_sys_r & `SUC_SYS_MASK)
                      | ({7'h00, pin_high} << `SUC_BIT_PIN)
                      | ({7'h00, sif.hold} << `SUC_BIT_HOLD);

   assign rd_mux = rd_sys  ? buf_sys_r :
                   rd_upd  ? {7'h00, upd_r} :
                   rd_stat ? stat_byte :
                             `SUC_RST_BYTE;

   // Active values drive the power-down outputs; hold and event come from the controller
   assign sync_pd_out     = act_sys_r[`SUC_BIT_PD_SYNC];
   assign dist_ref_pd_out = act_sys_r[`SUC_BIT_PD_DREF];
   assign chan_hold_out   = sif.hold;
   assign sync_event_out  = sif.sync_event;
   assign update_out      = upd_r;
   assign reg_rdata_out   = rdata_r;

   assign sif.soft_sync = act_sys_r[`SUC_BIT_SOFT];
   assign sif.sync_pd   = act_sys_r[`SUC_BIT_PD_SYNC];
   assign sif.pin_high  = pin_high;

   // Buffer register takes writes
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         buf_sys_r <= `SUC_RST_BYTE;
      end else if (wr_sys) begin
         buf_sys_r <= reg_wdata_in & `SUC_SYS_MASK;
      end
   end

   // Active register loads only on update
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         act_sys_r <= `SUC_RST_BYTE;
      end else if (upd_r) begin
         act_sys_r <= buf_sys_r;
      end
   end

   // Update strobe clears itself one cycle later
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         upd_r <= 1'b0;
      end else begin
         upd_r <= upd_set;
      end
   end

   // Read data valid only in the cycle after the read strobe
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         rdata_r <= `SUC_RST_BYTE;
      end else begin
         rdata_r <= reg_rd_in ? rd_mux : `SUC_RST_BYTE;
      end
   end

   suc_pin_sync u_pin (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .pin_in     (sync_pin_b_in),
      .level_out  (pin_high)
   );

   suc_sync_ctl u_ctl (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .sif        (sif.ctl)
   );

   // Checks
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   a_upd_pulse_set:
   assert property (upd_set |=> update_out)
      else $error("Update write did not raise update strobe");

   a_upd_copies_buf:
   assert property (update_out |=> act_sys_r == $past(buf_sys_r))
      else $error("Active register not loaded from buffer");

   a_upd_self_clear:
   assert property (update_out && !upd_set |=> !update_out)
      else $error("Update strobe did not clear itself");

   a_act_held_stable:
   assert property (!update_out |=> $stable(act_sys_r))
      else $error("Active register changed without update");

   a_pd_blocks_sync:
   assert property (sync_pd_out && $past(sync_pd_out)
                    |-> !chan_hold_out && !sync_event_out)
      else $error("Sync activity while sync powered down");

   a_dref_pd_update:
   assert property ($changed(dist_ref_pd_out) |-> $past(update_out))
      else $error("Reference power-down changed without update");

   a_soft_hold_set:
   assert property ((sif.soft_sync && !sync_pd_out) [*2]
                    |-> chan_hold_out)
      else $error("Soft sync did not hold channels");

   a_soft_fall_sync:
   assert property ($fell(sif.soft_sync) && chan_hold_out && pin_high
                    && !sync_pd_out |=> sync_event_out)
      else $error("Soft sync release gave no sync event");

   a_event_on_release:
   assert property (sync_event_out |-> $fell(chan_hold_out))
      else $error("Sync event without hold release");

   a_reset_soft_zero:
   assert property (@(posedge ref_clk_in) disable iff (1'b0)
                    !rst_b_in |=> !act_sys_r[`SUC_BIT_SOFT]
                    && !buf_sys_r[`SUC_BIT_SOFT])
      else $error("Soft sync not cleared by reset");

   a_rd_sys_data:
   assert property (reg_rd_in && rd_sys |=> reg_rdata_out
                    == $past(buf_sys_r))
      else $error("System register read data wrong");
endmodule

// ---- verilog/suc_cfg.svh ----
// Constants for the sync and update control block
// Notes on behaviour
// - Bit 2 of the system register at 1 powers down output synchronization.
// - Bit 1 of the system register at 1 powers down distribution reference.
// - Soft sync bit held at 1 forces selected channels static, like sync pin low.
// - Soft sync falling from 1 to 0 triggers a sync, like the pin rising.
// - Soft sync resets to 0, so software holds no channel after reset.
// - Writing 1 to update bit 0 copies all buffer registers into active ones.
// - The update bit clears itself after the transfer.
`ifndef SUC_CFG_SVH
`define SUC_CFG_SVH
`define SUC_ADDR_W      12
`define SUC_DATA_W      8
`define SUC_OFS_SYS     12'h230
`define SUC_OFS_UPD     12'h232
`define SUC_OFS_STAT    12'h234
`define SUC_BIT_PD_SYNC 2
`define SUC_BIT_PD_DREF 1
`define SUC_BIT_SOFT    0
`define SUC_BIT_UPD     0
`define SUC_BIT_HOLD    3
`define SUC_BIT_PIN     4
`define SUC_SYS_MASK    8'h07
`define SUC_RST_BYTE    8'h00
`endif

// ---- verilog/suc_pkg.sv ----
// Types and helpers for the sync and update control block
`include "suc_cfg.svh"
package suc_pkg;
   typedef logic [`SUC_ADDR_W-1:0] suc_addr_t;
   typedef logic [`SUC_DATA_W-1:0] suc_byte_t;
   typedef enum logic {SUC_RUN, SUC_HOLD} suc_sync_st_t;

   function automatic logic suc_hit(input suc_addr_t a, input suc_addr_t ofs);
      suc_hit = (a == ofs);
   endfunction
endpackage

// ---- verilog/suc_sync_if.sv ----
// Signals between the register bank and the sync controller
interface suc_sync_if;
   logic soft_sync;
   logic sync_pd;
   logic pin_high;
   logic hold;
   logic sync_event;
   modport bank (output soft_sync, output sync_pd, output pin_high,
                 input hold, input sync_event);
   modport ctl  (input soft_sync, input sync_pd, input pin_high,
                 output hold, output sync_event);
endinterface

// ---- verilog/suc_pin_sync.sv ----
// Three-stage synchronizer for the external sync pin
module suc_pin_sync (
   input  wire logic ref_clk_in,
   input  wire logic rst_b_in,
   input  wire logic pin_in,
   output logic      level_out
);
   import suc_pkg::*;
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   logic agree;

   assign agree     = (s2_r == s3_r);
   assign level_out = level_r;

   // Pin idles high, so reset to high
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         s1_r    <= 1'b1;
         s2_r    <= 1'b1;
         s3_r    <= 1'b1;
         level_r <= 1'b1;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) begin
            level_r <= s3_r;
         end
      end
   end
endmodule

// ---- verilog/suc_sync_ctl.sv ----
// Static hold and sync event generation
module suc_sync_ctl (
   input  wire logic ref_clk_in,
   input  wire logic rst_b_in,
   suc_sync_if.ctl   sif
);
   import suc_pkg::*;
   suc_sync_st_t st_r;
   suc_sync_st_t st_nxt;
   logic         evt_r;
   logic         evt_nxt;
   logic         hold_req;

   // Soft bit high or pin low asks for hold, unless sync is powered down
   assign hold_req = (sif.soft_sync | ~sif.pin_high) & ~sif.sync_pd;
   assign sif.hold       = (st_r == SUC_HOLD);
   assign sif.sync_event = evt_r;

   always_comb begin
      st_nxt  = st_r;
      evt_nxt = 1'b0;
      case (st_r)
         SUC_RUN: begin
            if (hold_req) begin
               st_nxt = SUC_HOLD;
            end
         end
         SUC_HOLD: begin
            if (sif.sync_pd) begin
               st_nxt = SUC_RUN;
            end else if (!hold_req) begin
               st_nxt  = SUC_RUN;
               evt_nxt = 1'b1;
            end
         end
         default: begin
            st_nxt = SUC_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         st_r  <= SUC_RUN;
         evt_r <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         evt_r <= evt_nxt;
      end
   end
endmodule

// ---- dv/test_sync_and_update_control.sv ----
// Self-checking testbench for the sync and update register bank
`include "suc_cfg.svh"
module test_sync_and_update_control;
   timeunit 1ns;
   timeprecision 1ns;
   import suc_pkg::*;
   logic      ref_clk_in = 1'b0;
   logic      rst_b_in = 1'b0;
   suc_addr_t addr = '0;
   suc_byte_t wdata = '0;
   logic      wr = 1'b0;
   logic      rd = 1'b0;
   logic      pin_b = 1'b1;
   suc_byte_t rdata;
   logic      sync_pd, dist_pd, hold, ev, upd;
   logic      rd_p = 1'b0;
   logic      pin_e = 1'b1;
   logic      hold_e = 1'b0;
   suc_byte_t act = '0;
   suc_byte_t up_cnt = '0;
   suc_byte_t ev_cnt = '0;
   suc_byte_t exp_up = '0;
   suc_byte_t exp_ev = '0;
   suc_byte_t rnd = '0;
   suc_byte_t exp_q[$];
   int        bad_count = 0;
   int        comparisons = 0;
   int        cyc = 0;

   suc_top u_suc_top (
      .ref_clk_in      (ref_clk_in),
      .rst_b_in        (rst_b_in),
      .reg_addr_in     (addr),
      .reg_wdata_in    (wdata),
      .reg_wr_in       (wr),
      .reg_rd_in       (rd),
      .reg_rdata_out   (rdata),
      .sync_pin_b_in   (pin_b),
      .sync_pd_out     (sync_pd),
      .dist_ref_pd_out (dist_pd),
      .chan_hold_out   (hold),
      .sync_event_out  (ev),
      .update_out      (upd)
   );

   always #50 ref_clk_in = ~ref_clk_in;

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input suc_byte_t e, input suc_byte_t g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Monitor: read data the cycle after a read, otherwise zero
   always @(posedge ref_clk_in) rd_p <= rd;
   always @(negedge ref_clk_in) begin
      if (rd_p)
         chk("rdata", exp_q.pop_front(), rdata);
      else
         chk("rdata idle", 8'h00, rdata);
      if (upd === 1'b1) up_cnt++;
      if (ev === 1'b1) ev_cnt++;
   end

   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic wr_reg(input suc_addr_t a, input suc_byte_t d);
      @(posedge ref_clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk_in);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input suc_addr_t a, input suc_byte_t e);
      @(posedge ref_clk_in);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge ref_clk_in);
      rd <= 1'b0;
   endtask

   task automatic st_chk();
      rd_reg(`SUC_OFS_STAT, {3'h0, pin_e, hold_e, act[2:0]});
   endtask

   task automatic outs_chk();
      chk("outputs", {5'h0, act[2], act[1], hold_e},
          {5'h0, sync_pd, dist_pd, hold});
      chk("updates", exp_up, up_cnt);
      chk("events", exp_ev, ev_cnt);
   endtask

   task automatic set_sys(input suc_byte_t s, input logic h, input logic e);
      wr_reg(`SUC_OFS_SYS, s);
      rd_reg(`SUC_OFS_SYS, s & `SUC_SYS_MASK);
      st_chk();
      wr_reg(`SUC_OFS_UPD, 8'h01);
      repeat (4) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      act = s & `SUC_SYS_MASK;
      hold_e = h;
      exp_up++;
      exp_ev += {7'h0, e};
      outs_chk();
      st_chk();
      rd_reg(`SUC_OFS_UPD, 8'h00);
   endtask

   task automatic pin_step(input logic lvl, input logic e);
      @(posedge ref_clk_in);
      pin_b <= lvl;
      repeat (8) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      pin_e = lvl;
      hold_e = ~lvl;
      exp_ev += {7'h0, e};
      outs_chk();
      st_chk();
   endtask

   initial begin
      void'($urandom(32'h94c6c65d));
      repeat (3) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      @(negedge ref_clk_in);
      outs_chk();
      rd_reg(`SUC_OFS_SYS, `SUC_RST_BYTE);
      rd_reg(`SUC_OFS_UPD, `SUC_RST_BYTE);
      st_chk();
      wr_reg(12'h231, 8'hff);
      rd_reg(12'h231, 8'h00);
      rd_reg(12'h233, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rnd = {5'($urandom_range(31, 0)), i[1:0], 1'b0};
         set_sys(rnd, 1'b0, 1'b0);
      end
      wr_reg(`SUC_OFS_UPD, 8'hfe);
      repeat (3) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      outs_chk();
      set_sys(8'h01, 1'b1, 1'b0);
      set_sys(8'hf8, 1'b0, 1'b1);
      set_sys(8'h01, 1'b1, 1'b0);
      set_sys(8'h05, 1'b0, 1'b0);
      set_sys(8'h04, 1'b0, 1'b0);
      set_sys(8'h00, 1'b0, 1'b0);
      pin_step(1'b0, 1'b0);
      pin_step(1'b1, 1'b1);
      repeat (2) @(posedge ref_clk_in);
      close_out();
   end
endmodule
